// ===== crr_params.svh
/*
  Constants for the cable reflectometry register bank: register indices,
  reset values, field positions and timing counts.
  Assumes it is included by bare name; definitions only.
*/
`ifndef CRR_PARAMS_SVH
`define CRR_PARAMS_SVH

// Register indices; byte address is four times the index
`define CRR_IDX_W 10
`define CRR_IDX_GEN_CFG 10'h180
`define CRR_IDX_PEAK_A12 10'h190
`define CRR_IDX_PEAK_A34 10'h191
`define CRR_IDX_PEAK_A5B1 10'h192
`define CRR_IDX_PEAK_B23 10'h193
`define CRR_IDX_PEAK_B45 10'h194

// Wishbone geometry
`define CRR_ADR_W 12
`define CRR_DAT_W 32
`define CRR_SEL_W 4
`define CRR_REG_W 16

// Configuration field layout, bits 12:0 of the register
`define CRR_CFG_W 13
`define CRR_CFG_RESET 13'h0752
`define CRR_AVG_LO 7
`define CRR_AVG_HI 9
`define CRR_AVG_RSVD 3'h7
`define CRR_AVG_ONE 7'h01

// Result layout
`define CRR_PEAK_W 8
`define CRR_PEAKS 5
`define CRR_PEAK_RESET 8'h00
`define CRR_CHAN_A 1'b0
`define CRR_CHAN_B 1'b1

// Channel masks, bit 0 is channel A
`define CRR_CHAN_N 4
`define CRR_MASK_ALL 4'hf
`define CRR_MASK_AB 4'h3
`define CRR_MASK_NONE 4'h0

// Timing: microsecond length and clock period in nanoseconds
`define CRR_NS_PER_US 1000
`define CRR_CLK_NS 20
`define CRR_CYC_PER_US ((`CRR_NS_PER_US) / (`CRR_CLK_NS))
`define CRR_US_CNT_W 6
`define CRR_PER_W 4
`define CRR_PER_ONE 4'h1

`endif

// ===== crr_pkg.sv
/*
  Types for the cable reflectometry register bank.
  Assumes crr_params.svh is on the include path.
*/
`include "crr_params.svh"

package crr_pkg;

  // Field order matches register bits 12:0
  typedef struct packed {
    logic pair_cd_skip;
    logic cross_listen_off;
    logic link_pulse_watch;
    logic [2:0] average_count;
    logic [2:0] segment_count;
    logic [3:0] cycle_period_us;
  } crr_cfg_type;

  typedef logic [`CRR_PEAKS-1:0][`CRR_PEAK_W-1:0] crr_peaks_type;

  typedef struct packed {
    logic valid;
    logic chan;
    crr_peaks_type peaks;
  } crr_result_type;

  typedef enum logic [0:0] {
    CRR_BUS_IDLE = 1'b0,
    CRR_BUS_ACK = 1'b1
  } crr_bus_state_type;

endpackage : crr_pkg

// ===== crr_peak_store.sv
/*
  Holds the peak positions of one channel.
  Assumes load_i is a one-cycle pulse from logic on the same clock.
*/
`timescale 1ns/1ps
`include "crr_params.svh"

module crr_peak_store #(
  parameter int PEAKS = `CRR_PEAKS,
  parameter int WIDTH = `CRR_PEAK_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [PEAKS-1:0][WIDTH-1:0] peaks_i,
  output logic [PEAKS-1:0][WIDTH-1:0] peaks_o
);

  logic [PEAKS-1:0][WIDTH-1:0] peak_ff;
  logic [PEAKS-1:0][WIDTH-1:0] nxt_peak;

  genvar g;
  generate
    for (g = 0; g < PEAKS; g++) begin : g_peak
      always_comb begin
        nxt_peak[g] = load_i ? peaks_i[g] : peak_ff[g];
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          peak_ff[g] <= WIDTH'(`CRR_PEAK_RESET);
        end else begin
          peak_ff[g] <= nxt_peak[g];
        end
      end
    end
  endgenerate

  assign peaks_o = peak_ff;

endmodule : crr_peak_store

// ===== crr_regs.sv
/*
  Register bank for the cable reflectometry diagnostic: one general
  configuration register and the peak position results of channels A and B,
  reached over a classic Wishbone slave.
  Assumes the reflectometry engine runs on clk_i, so its signals need no
  synchroniser, and that the bus master holds each request until ack.
*/
`timescale 1ns/1ps
`include "crr_params.svh"

module crr_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`CRR_ADR_W-1:0] wb_adr_i,
  input wire logic [`CRR_SEL_W-1:0] wb_sel_i,
  input wire logic [`CRR_DAT_W-1:0] wb_dat_i,
  output logic [`CRR_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic tdr_busy_i,
  input wire logic silence_i,
  input wire logic [1:0] tx_chan_i,
  input wire crr_pkg::crr_result_type result_i,
  output crr_pkg::crr_cfg_type cfg_o,
  output logic [`CRR_CHAN_N-1:0] test_chan_mask_o,
  output logic [`CRR_CHAN_N-1:0] listen_mask_o,
  output logic link_pulse_watch_o,
  output logic [6:0] average_cycles_o,
  output logic [2:0] segment_count_o,
  output logic [3:0] cycle_period_us_o,
  output logic cycle_tick_o
);

  // Bus slave state
  crr_pkg::crr_bus_state_type bus_ff;
  crr_pkg::crr_bus_state_type nxt_bus;
  logic [`CRR_DAT_W-1:0] rdat_ff;
  logic [`CRR_DAT_W-1:0] nxt_rdat;

  // Configuration state
  crr_pkg::crr_cfg_type cfg_ff;
  crr_pkg::crr_cfg_type nxt_cfg;
  logic avg_rsvd_ff;
  logic nxt_avg_rsvd;

  // Engine-facing outputs, registered
  logic [`CRR_CHAN_N-1:0] test_mask_ff;
  logic [`CRR_CHAN_N-1:0] nxt_test_mask;
  logic [`CRR_CHAN_N-1:0] listen_mask_ff;
  logic [`CRR_CHAN_N-1:0] nxt_listen_mask;
  logic watch_ff;
  logic nxt_watch;
  logic [6:0] avg_cycles_ff;
  logic [6:0] nxt_avg_cycles;

  // Cycle timer
  logic [`CRR_US_CNT_W-1:0] us_cnt_ff;
  logic [`CRR_US_CNT_W-1:0] nxt_us_cnt;
  logic [`CRR_PER_W-1:0] per_cnt_ff;
  logic [`CRR_PER_W-1:0] nxt_per_cnt;
  logic tick_ff;
  logic nxt_tick;

  // Decode
  logic [`CRR_IDX_W-1:0] idx;
  logic req;
  logic wr_cfg;
  logic [`CRR_REG_W-1:0] lane_mask;
  logic [`CRR_REG_W-1:0] cfg_word;
  logic [`CRR_REG_W-1:0] merged;
  logic [2:0] avg_wr;
  crr_pkg::crr_cfg_type wr_val;
  logic [`CRR_REG_W-1:0] cfg_rd;
  logic [`CRR_REG_W-1:0] reg_rd;
  logic us_wrap;
  logic [`CRR_PER_W-1:0] per_target;

  // Results
  crr_pkg::crr_peaks_type peaks_a;
  crr_pkg::crr_peaks_type peaks_b;
  logic load_a;
  logic load_b;

  assign idx = wb_adr_i[`CRR_ADR_W-1:2];
  assign req = wb_cyc_i & wb_stb_i;

  // Writes land on the edge where the master sees ack high
  assign wr_cfg = req & wb_we_i & (bus_ff == crr_pkg::CRR_BUS_ACK) & (idx == `CRR_IDX_GEN_CFG);

  assign load_a = result_i.valid & (result_i.chan == `CRR_CHAN_A);
  assign load_b = result_i.valid & (result_i.chan == `CRR_CHAN_B);

  crr_peak_store #(
    .PEAKS(`CRR_PEAKS),
    .WIDTH(`CRR_PEAK_W)
  ) u_store_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(load_a),
    .peaks_i(result_i.peaks),
    .peaks_o(peaks_a)
  );

  crr_peak_store #(
    .PEAKS(`CRR_PEAKS),
    .WIDTH(`CRR_PEAK_W)
  ) u_store_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(load_b),
    .peaks_i(result_i.peaks),
    .peaks_o(peaks_b)
  );

  // Byte lanes 0 and 1 carry the 16-bit register
  always_comb begin
    lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    cfg_word = {3'h0, cfg_ff};
    merged = (wb_dat_i[`CRR_REG_W-1:0] & lane_mask) | (cfg_word & ~lane_mask);
    // Struct view keeps field positions in one place, the package type
    wr_val = merged[`CRR_CFG_W-1:0];
    avg_wr = wr_val.average_count;
  end

  // Configuration register
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_avg_rsvd = avg_rsvd_ff;
    if (wr_cfg) begin
      nxt_cfg.pair_cd_skip = wr_val.pair_cd_skip;
      nxt_cfg.cross_listen_off = wr_val.cross_listen_off;
      nxt_cfg.link_pulse_watch = wr_val.link_pulse_watch;
      nxt_cfg.segment_count = wr_val.segment_count;
      nxt_cfg.cycle_period_us = wr_val.cycle_period_us;
      // Only a write touching the field's lanes counts as a new code
      if (wb_sel_i[1] | wb_sel_i[0]) begin
        if (avg_wr == `CRR_AVG_RSVD) begin
          nxt_avg_rsvd = 1'b1;
        end else begin
          nxt_cfg.average_count = avg_wr;
          nxt_avg_rsvd = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_ff <= `CRR_CFG_RESET;
      avg_rsvd_ff <= 1'b0;
    end else begin
      cfg_ff <= nxt_cfg;
      avg_rsvd_ff <= nxt_avg_rsvd;
    end
  end

  // Read value of the configuration register
  always_comb begin
    cfg_rd = {3'h0, cfg_ff};
    if (avg_rsvd_ff) begin
      cfg_rd[`CRR_AVG_HI:`CRR_AVG_LO] = 3'h0;
    end
  end

  // Read mux for configuration and result registers; writes to results fall through to nothing
  always_comb begin
    case (idx)
      `CRR_IDX_GEN_CFG: reg_rd = cfg_rd;
      `CRR_IDX_PEAK_A12: reg_rd = {peaks_a[1], peaks_a[0]};
      `CRR_IDX_PEAK_A34: reg_rd = {peaks_a[3], peaks_a[2]};
      `CRR_IDX_PEAK_A5B1: reg_rd = {peaks_b[0], peaks_a[4]};
      `CRR_IDX_PEAK_B23: reg_rd = {peaks_b[2], peaks_b[1]};
      `CRR_IDX_PEAK_B45: reg_rd = {peaks_b[4], peaks_b[3]};
      default: reg_rd = 16'h0000;
    endcase
  end

  // Bus slave: one wait cycle, then ack for one cycle
  always_comb begin
    nxt_bus = bus_ff;
    nxt_rdat = rdat_ff;
    case (bus_ff)
      crr_pkg::CRR_BUS_IDLE: begin
        if (req) begin
          nxt_bus = crr_pkg::CRR_BUS_ACK;
          nxt_rdat = {16'h0000, reg_rd};
        end
      end
      crr_pkg::CRR_BUS_ACK: begin
        nxt_bus = crr_pkg::CRR_BUS_IDLE;
      end
      default: begin
        nxt_bus = crr_pkg::CRR_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_ff <= crr_pkg::CRR_BUS_IDLE;
      rdat_ff <= 32'h00000000;
    end else begin
      bus_ff <= nxt_bus;
      rdat_ff <= nxt_rdat;
    end
  end

  // Engine controls
  always_comb begin
    if (cfg_ff.pair_cd_skip) begin
      nxt_test_mask = `CRR_MASK_AB;
    end else begin
      nxt_test_mask = `CRR_MASK_ALL;
    end
    if (cfg_ff.cross_listen_off) begin
      nxt_listen_mask = `CRR_CHAN_N'(1) << tx_chan_i;
    end else begin
      nxt_listen_mask = nxt_test_mask;
    end
    // Never listen on a channel that is left out of the test
    nxt_listen_mask = nxt_listen_mask & nxt_test_mask;
    nxt_watch = cfg_ff.link_pulse_watch & tdr_busy_i & silence_i;
    nxt_avg_cycles = `CRR_AVG_ONE << cfg_ff.average_count;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      test_mask_ff <= `CRR_MASK_ALL;
      listen_mask_ff <= `CRR_MASK_NONE;
      watch_ff <= 1'b0;
      avg_cycles_ff <= `CRR_AVG_ONE;
    end else begin
      test_mask_ff <= nxt_test_mask;
      listen_mask_ff <= nxt_listen_mask;
      watch_ff <= nxt_watch;
      avg_cycles_ff <= nxt_avg_cycles;
    end
  end

  // Cycle timer: microsecond prescaler, then period counter
  always_comb begin
    // A zero period would never end a cycle, so it runs as one microsecond
    if (cfg_ff.cycle_period_us == 4'h0) begin
      per_target = `CRR_PER_ONE;
    end else begin
      per_target = cfg_ff.cycle_period_us;
    end
    us_wrap = (us_cnt_ff == `CRR_US_CNT_W'(`CRR_CYC_PER_US - 1));
    nxt_us_cnt = us_cnt_ff;
    nxt_per_cnt = per_cnt_ff;
    nxt_tick = 1'b0;
    if (!tdr_busy_i) begin
      nxt_us_cnt = '0;
      nxt_per_cnt = '0;
    end else if (us_wrap) begin
      nxt_us_cnt = '0;
      if (per_cnt_ff >= per_target - `CRR_PER_ONE) begin
        nxt_per_cnt = '0;
        nxt_tick = 1'b1;
      end else begin
        nxt_per_cnt = per_cnt_ff + `CRR_PER_ONE;
      end
    end else begin
      nxt_us_cnt = us_cnt_ff + `CRR_US_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      us_cnt_ff <= '0;
      per_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      us_cnt_ff <= nxt_us_cnt;
      per_cnt_ff <= nxt_per_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign wb_ack_o = (bus_ff == crr_pkg::CRR_BUS_ACK);
  assign wb_dat_o = rdat_ff;
  assign cfg_o = cfg_ff;
  assign test_chan_mask_o = test_mask_ff;
  assign listen_mask_o = listen_mask_ff;
  assign link_pulse_watch_o = watch_ff;
  assign average_cycles_o = avg_cycles_ff;
  assign segment_count_o = cfg_ff.segment_count;
  assign cycle_period_us_o = cfg_ff.cycle_period_us;
  assign cycle_tick_o = tick_ff;

endmodule : crr_regs

// ===== crr_regs_props.sv
/*
  Checker for the reflectometry register bank: configuration fields,
  engine outputs and configuration read data.
  Assumes it is bound to crr_regs and sees only its ports.
*/
`timescale 1ns/1ps
`include "crr_params.svh"

module crr_regs_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_we_i,
  input wire logic [`CRR_ADR_W-1:0] wb_adr_i,
  input wire logic [`CRR_SEL_W-1:0] wb_sel_i,
  input wire logic [`CRR_DAT_W-1:0] wb_dat_i,
  input wire logic [`CRR_DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic tdr_busy_i,
  input wire logic silence_i,
  input wire logic [1:0] tx_chan_i,
  input wire crr_pkg::crr_cfg_type cfg_o,
  input wire logic [`CRR_CHAN_N-1:0] test_chan_mask_o,
  input wire logic [`CRR_CHAN_N-1:0] listen_mask_o,
  input wire logic link_pulse_watch_o,
  input wire logic [6:0] average_cycles_o,
  input wire logic [2:0] segment_count_o,
  input wire logic [3:0] cycle_period_us_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Low lane of a configuration write, at the edge where it lands
  sequence cfg_write_s;
    wb_ack_o && wb_we_i && wb_adr_i[11:2] == `CRR_IDX_GEN_CFG && wb_sel_i[0];
  endsequence

  // Guard on past reset: outputs still hold reset values one edge later
  a_cd_skip: assert property (!$past(rst_i) |-> test_chan_mask_o == ($past(cfg_o.pair_cd_skip) ? 4'h3 : 4'hf))
    else $error("test mask wrong");
  a_listen_own: assert property (!$past(rst_i) && $past(cfg_o.cross_listen_off) |->
    (listen_mask_o & ~(4'h1 << $past(tx_chan_i))) == 4'h0) else $error("listen mask wrong");
  a_watch_gate: assert property (!$past(rst_i) |->
    link_pulse_watch_o == $past(cfg_o.link_pulse_watch & tdr_busy_i & silence_i)) else $error("watch wrong");
  a_avg_pow: assert property (!$past(rst_i) |-> average_cycles_o == (7'h01 << $past(cfg_o.average_count)))
    else $error("average cycles wrong");
  a_avg_legal: assert property (cfg_o.average_count != `CRR_AVG_RSVD)
    else $error("reserved average stored");
  a_seg_field: assert property (cfg_write_s |=> segment_count_o == $past(wb_dat_i[6:4]))
    else $error("segment count wrong");
  a_period_field: assert property (cfg_write_s |=> cycle_period_us_o == $past(wb_dat_i[3:0]))
    else $error("cycle period wrong");
  a_cfg_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i[11:2] == `CRR_IDX_GEN_CFG |->
    wb_dat_o[15:10] == {3'h0, cfg_o[12:10]} && wb_dat_o[6:0] == cfg_o[6:0]) else $error("config read wrong");
endmodule : crr_regs_props

// ===== crr_regs_bench.sv
/*
  Self-checking bench for crr_regs: Wishbone reads and writes, engine
  outputs and peak result loading.
  Assumes crr_pkg and crr_regs_props are compiled first.
*/
`timescale 1ns/1ps
`include "crr_params.svh"

module crr_regs_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic ack, lpw, tick;
  logic busy = 1'b0;
  logic sil = 1'b0;
  logic [1:0] txc = 2'h0;
  crr_pkg::crr_result_type res = '0;
  crr_pkg::crr_cfg_type cfg;
  crr_pkg::crr_peaks_type pa = '0;
  crr_pkg::crr_peaks_type pb = '0;
  logic [3:0] tmask, lmask, per;
  logic [6:0] avg;
  logic [2:0] seg;
  logic [12:0] st = 13'h0752;
  logic rz = 1'b0;
  int n_fail = 0;
  int n_compared = 0;
  int cnt = 0;

  crr_regs dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dat_o), .wb_ack_o(ack), .tdr_busy_i(busy), .silence_i(sil),
    .tx_chan_i(txc), .result_i(res), .cfg_o(cfg), .test_chan_mask_o(tmask), .listen_mask_o(lmask),
    .link_pulse_watch_o(lpw), .average_cycles_o(avg), .segment_count_o(seg), .cycle_period_us_o(per),
    .cycle_tick_o(tick));

  initial forever #10 clk_i = ~clk_i;

  task end_sim;
    if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // Generous ceiling; the whole sequence needs well under a thousand cycles
  always @(posedge clk_i) begin
    cnt <= cnt + 1;
    if (cnt == 5000) begin
      n_fail++;
      end_sim;
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [9:0] i, input logic [31:0] d, input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    wd <= d;
    sel <= s;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  function automatic logic [3:0] exp_tm();
    return st[12] ? 4'h3 : 4'hf;
  endfunction : exp_tm

  // Lanes merge with the stored value; a merged code 111 keeps the old code
  task automatic cfg_wr(input logic [31:0] d, input logic [3:0] s);
    logic [12:0] m;
    m = st;
    if (s[0]) m[7:0] = d[7:0];
    if (s[1]) m[12:8] = d[12:8];
    rz = (m[9:7] == 3'h7);
    if (rz) m[9:7] = st[9:7];
    st = m;
    busy <= 1'($urandom);
    sil <= 1'($urandom);
    txc <= 2'($urandom);
    bus(1'b1, `CRR_IDX_GEN_CFG, d, s);
    repeat (2) @(posedge clk_i);
    chk("test_mask", exp_tm(), tmask);
    chk("listen_mask", st[11] ? ((4'h1 << txc) & exp_tm()) : exp_tm(), lmask);
    chk("watch", st[10] & busy & sil, lpw);
    chk("avg_cycles", 7'h01 << st[9:7], avg);
    chk("segments", st[6:4], seg);
    chk("period", st[3:0], per);
    bus(1'b0, `CRR_IDX_GEN_CFG, 32'h0, 4'h3);
    chk("cfg_read", {19'h0, st[12:10], rz ? 3'h0 : st[9:7], st[6:0]}, rdat);
  endtask : cfg_wr

  // Clocks per cycle; a zero period runs as one microsecond
  function automatic logic [31:0] exp_ticks(input logic [3:0] p);
    return (p == 4'h0 ? 32'h1 : 32'(p)) * `CRR_CYC_PER_US;
  endfunction : exp_ticks

  // First tick one edge late for the registered tick output, then a steady gap
  task automatic tick_chk(input logic [3:0] p);
    int n;
    cfg_wr({24'h0, st[7:4], p}, 4'h1);
    busy <= 1'b0;
    @(posedge clk_i);
    busy <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (tick !== 1'b1);
    chk("tick_first", exp_ticks(p) + 32'h1, n);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (tick !== 1'b1);
    chk("tick_gap", exp_ticks(p), n);
    busy <= 1'b0;
  endtask : tick_chk

  task automatic load(input logic ch, input crr_pkg::crr_peaks_type p);
    res.valid <= 1'b1;
    res.chan <= ch;
    res.peaks <= p;
    @(posedge clk_i);
    res.valid <= 1'b0;
    @(posedge clk_i);
  endtask : load

  task automatic peaks_chk;
    logic [79:0] ap;
    ap = {pb, pa};
    for (int k = 0; k < 5; k++) begin
      bus(1'b0, 10'(10'h190 + k), 32'h0, 4'h3);
      chk("peaks", {16'h0, ap[16*k +: 16]}, rdat);
    end
  endtask : peaks_chk

  initial begin
    void'($urandom(32'h784e));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    peaks_chk;
    bus(1'b1, 10'h1a0, $urandom, 4'hf);
    bus(1'b0, 10'h1a0, 32'h0, 4'h3);
    chk("unmapped", 32'h0, rdat);
    bus(1'b0, `CRR_IDX_GEN_CFG, 32'h0, 4'h3);
    chk("cfg_reset", 32'h0752, rdat);
    cfg_wr(32'hffffffff, 4'h3);
    cfg_wr(32'h0, 4'h3);
    repeat (14) cfg_wr($urandom, 4'(1 + $urandom % 3));
    for (int r = 0; r < 2; r++) begin
      pa = 40'({$urandom, $urandom});
      load(`CRR_CHAN_A, pa);
      if (r == 0) begin
        pb = 40'({$urandom, $urandom});
        load(`CRR_CHAN_B, pb);
      end
      bus(1'b1, 10'h190 + 10'(r), $urandom, 4'hf);
      peaks_chk;
    end
    tick_chk(4'h1);
    tick_chk(4'h3);
    tick_chk(4'h0);
    end_sim;
  end
endmodule : crr_regs_bench

bind crr_regs crr_regs_props u_props (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .tdr_busy_i(tdr_busy_i),
  .silence_i(silence_i),
  .tx_chan_i(tx_chan_i),
  .cfg_o(cfg_o),
  .test_chan_mask_o(test_chan_mask_o),
  .listen_mask_o(listen_mask_o),
  .link_pulse_watch_o(link_pulse_watch_o),
  .average_cycles_o(average_cycles_o),
  .segment_count_o(segment_count_o),
  .cycle_period_us_o(cycle_period_us_o)
);
